// >>> cpmc_pkg.sv
// Purpose: shared constants and types
// Assumes: 125 MHz clock, AXI4-Lite access
// Notes: offsets are byte addresses
package cpmc_pkg;
   localparam int CLK_MHZ = 125;
   localparam int CLK_HZ = CLK_MHZ * 1000000;
   localparam int ADDR_W = 8;
   // register byte offsets
   localparam logic [7:0] OFS_CLK_CFG = 8'h00;
   localparam logic [7:0] OFS_PLL_DIV = 8'h04;
   localparam logic [7:0] OFS_STATUS = 8'h08;
   localparam logic [7:0] OFS_MODE = 8'h0c;
   localparam logic [7:0] OFS_TEMPLATE = 8'h10;
   localparam logic [7:0] OFS_ALT_TEMPLATE = 8'h14;
   localparam logic [7:0] OFS_SLOW_TICK = 8'h18;
   localparam logic [7:0] OFS_FAST_TICK = 8'h1c;
   localparam logic [7:0] OFS_TICK_CFG = 8'h20;
   // field positions
   localparam int CFG_FREQ_LSB = 0;
   localparam int CFG_DBL_SRC_LSB = 3;
   localparam int CFG_PLL_SRC_LSB = 5;
   localparam int CFG_PLL_EN = 7;
   localparam int CFG_DBL_EN = 8;
   localparam int DIV_IN_LSB = 0;
   localparam int DIV_FB_LSB = 8;
   localparam int ST_LOCK = 0;
   localparam int ST_MODE_LSB = 1;
   localparam int ST_CPU = 3;
   localparam int FT_TERM_LSB = 0;
   localparam int FT_IRQ_EN = 8;
   localparam int FT_CNT_LSB = 16;
   localparam int TC_SEL_LSB = 0;
   localparam int TC_EN = 4;
   // writable bits and reset values
   localparam logic [31:0] CLK_CFG_WMASK = 32'h0000_01ff;
   localparam logic [31:0] PLL_DIV_WMASK = 32'h0000_ff0f;
   localparam logic [31:0] TEMPLATE_WMASK = 32'h0000_ffff;
   localparam logic [31:0] FAST_WMASK = 32'h0000_011f;
   localparam logic [31:0] TICK_WMASK = 32'h0000_001f;
   localparam logic [31:0] CLK_CFG_RST = 32'h0000_0000;
   localparam logic [31:0] PLL_DIV_RST = 32'h0000_1000;
   localparam logic [31:0] TEMPLATE_RST = 32'h0000_ffff;
   localparam logic [31:0] ALT_TEMPLATE_RST = 32'h0000_fffe;
   localparam logic [31:0] FAST_RST = 32'h0000_001f;
   localparam logic [31:0] TICK_RST = 32'h0000_0000;
   localparam logic [2:0] FREQ_CODE_MAX = 3'h5;
   localparam logic [7:0] FB_DIV_MIN = 8'h04;
   // global power mode codes
   localparam logic [1:0] MODE_ACTIVE = 2'h0;
   localparam logic [1:0] MODE_ALT = 2'h1;
   localparam logic [1:0] MODE_SLEEP = 2'h2;
   localparam logic [1:0] MODE_HIB = 2'h3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // timing
   localparam int PLL_LOCK_US = 250;
   localparam int PLL_LOCK_CYC = PLL_LOCK_US * CLK_MHZ;
   localparam int SLEEP_RESUME_US = 15;
   localparam int SLEEP_RESUME_CYC = SLEEP_RESUME_US * CLK_MHZ;
   localparam int HIB_RESUME_US = 100;
   localparam int HIB_RESUME_CYC = HIB_RESUME_US * CLK_MHZ - 1;
   localparam int LS_100K_HZ = 100000;
   localparam int LS_HALF_CYC = CLK_HZ / (2 * LS_100K_HZ);
   localparam int DIV_33K_HALF = 3;
   localparam int DIV_1K_HALF = 100;
   typedef enum logic [2:0]
   {
      st_active,
      st_alt,
      st_sleep,
      st_hib,
      st_resume
   } cpmc_state_type;
endpackage

// >>> cpmc_top.sv
// Purpose: clock steering, tick counters, power modes
// Assumes: oscillators are analog, steered from here
// Notes: low-speed clocks come from the system clock
`timescale 1ns/1ns
// Overview of operation
// - divided clocks have 50 percent duty
// - main osc code picks 3, 6, 12, 24, 48, 62 MHz
// - doubler doubles main, crystal or fabric input
// - loop reference is main, crystal or fabric
// - dividers give 4032 ratios, 24 to 67 MHz
// - lock bit within 250 us; reference used until lock
// - lock routed out for an interrupt
// - low-speed clocks of 1, 33 and 100 kHz
// - 33 kHz is 100 kHz divided by three
// - 13-bit slow tick counts 1 kHz ticks
// - slow tick stops in hibernate, debug halt
// - slow tick clearable; its interrupts wake
// - 5-bit 100 kHz fast tick wraps at terminal
// - optional fast tick terminal interrupt
// - watch crystal gives one-second interrupt
// - template bits gate resource clocks
// - cleared processor enable returns on wakeup
// - wakeup forces active, processor on; boot active
// - sleep exit waits 15 us
// - hibernate wakes on pin only, under 100 us
// - wake on interrupts or reset sources
module cpmc_top
#(
   parameter int unsigned PLL_LOCK_CYCLES = cpmc_pkg::PLL_LOCK_CYC,
   parameter int unsigned HIB_RESUME_CYCLES = cpmc_pkg::HIB_RESUME_CYC
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic ce,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [cpmc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   output logic [1:0] s_axi_bresp,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   input wire logic [cpmc_pkg::ADDR_W-1:0] s_axi_araddr,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   input wire logic external_reset_pin_n,
   input wire logic io_wake_pin,
   input wire logic watch_crystal_osc,
   input wire logic watchdog_reset,
   input wire logic precision_reset,
   input wire logic wake_irq,
   input wire logic debug_halt,
   output logic [2:0] main_osc_freq_sel,
   output logic doubler_enable,
   output logic [1:0] doubler_src,
   output logic pll_enable,
   output logic [1:0] pll_ref_src,
   output logic [3:0] pll_in_div,
   output logic [7:0] pll_fb_div,
   output logic pll_lock,
   output logic pll_output_select,
   output logic low_speed_100k_clock,
   output logic low_speed_33k_clock,
   output logic low_speed_1k_clock,
   output logic slow_tick_irq,
   output logic fast_tick_irq,
   output logic second_tick_irq,
   output logic [15:0] resource_clk_en,
   output logic cpu_enable,
   output logic [1:0] power_mode
);
   import cpmc_pkg::*;

   typedef struct packed
   {
      logic [1:0] s_external_reset_pin;
      logic [1:0] s_io;
      logic [1:0] s_watch;
      logic watch_prev;
      logic aw_got;
      logic w_got;
      logic [7:0] aw_addr;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [31:0] clk_cfg;
      logic [31:0] pll_div;
      logic [31:0] template;
      logic [31:0] alt_template;
      logic [31:0] fast_cfg;
      logic [31:0] tick_cfg;
      logic lock;
      logic [14:0] lock_cnt;
      cpmc_state_type state;
      logic from_hib;
      logic [13:0] resume_cnt;
      logic cpu_run;
      logic [15:0] clk_en;
      logic [9:0] half_cnt;
      logic ls_100k;
      logic ls_33k;
      logic ls_1k;
      logic [1:0] div3;
      logic [6:0] div1k;
      logic [12:0] slow_cnt;
      logic [4:0] fast_cnt;
      logic [14:0] watch_cnt;
      logic slow_irq;
      logic fast_irq;
      logic second_irq;
   } cpmc_reg_type;

   cpmc_reg_type r;
   cpmc_reg_type next_r;
   logic [1:0] rst_q;
   logic rst_n;
   logic half_tick;
   logic rise_100k;
   logic rise_1k;
   logic wake_any;
   logic watch_rise;

   // byte-lane merge
   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] wd, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int i = 0; i < 4; i++)
      begin
         if (strb[i])
         begin
            res[i*8 +: 8] = wd[i*8 +: 8];
         end
      end
      return res;
   endfunction

   // low sel bits of count all zero
   function automatic logic period_hit(input logic [12:0] cnt,
      input logic [3:0] sel);
      logic [12:0] mask;
      mask = 13'((14'h0001 << sel) - 14'h0001);
      return (cnt & mask) == 13'h0000;
   endfunction

   // resume reports the mode being left
   function automatic logic [1:0] mode_code(input cpmc_state_type st,
      input logic hib);
      case (st)
         st_active: return MODE_ACTIVE;
         st_alt: return MODE_ALT;
         st_sleep: return MODE_SLEEP;
         st_hib: return MODE_HIB;
         st_resume: return hib ? MODE_HIB : MODE_SLEEP;
         default: return MODE_ACTIVE;
      endcase
   endfunction

   // reset released through two flops
   always_ff @(posedge clock or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_q <= 2'h0;
      end
      else if (ce)
      begin
         rst_q <= {rst_q[0], 1'b1};
      end
   end
   assign rst_n = rst_q[1];

   // low-speed strobes; 1k rises on a falling 100k edge
   assign half_tick = r.half_cnt == 10'(LS_HALF_CYC - 1);
   assign rise_100k = half_tick & ~r.ls_100k;
   assign rise_1k = half_tick & ~r.ls_1k
      & (r.div1k == 7'(DIV_1K_HALF - 1));
   assign watch_rise = r.s_watch[1] & ~r.watch_prev;
   assign wake_any = wake_irq | r.slow_irq | r.fast_irq | r.second_irq
      | ~r.s_external_reset_pin[1] | watchdog_reset | precision_reset | r.s_io[1];

   // one write and one read at a time
   assign s_axi_awready = ~r.aw_got;
   assign s_axi_wready = ~r.w_got;
   assign s_axi_arready = ~r.rvalid;

   always_comb
   begin
      logic [31:0] wv;
      logic mode_wr;
      logic slow_clr;
      logic [1:0] mode_val;
      wv = 32'h0000_0000;
      mode_wr = 1'b0;
      slow_clr = 1'b0;
      mode_val = MODE_ACTIVE;
      next_r = r;
      next_r.slow_irq = 1'b0;
      next_r.fast_irq = 1'b0;
      next_r.second_irq = 1'b0;
      // pin synchronisers
      next_r.s_external_reset_pin = {r.s_external_reset_pin[0], external_reset_pin_n};
      next_r.s_io = {r.s_io[0], io_wake_pin};
      next_r.s_watch = {r.s_watch[0], watch_crystal_osc};
      next_r.watch_prev = r.s_watch[1];

      // aw and w taken in either order
      if (s_axi_awvalid && !r.aw_got)
      begin
         next_r.aw_got = 1'b1;
         next_r.aw_addr = {s_axi_awaddr[7:2], 2'b00};
      end
      if (s_axi_wvalid && !r.w_got)
      begin
         next_r.w_got = 1'b1;
         next_r.w_data = s_axi_wdata;
         next_r.w_strb = s_axi_wstrb;
      end
      if (r.bvalid && s_axi_bready)
      begin
         next_r.bvalid = 1'b0;
      end

      // register write once both halves are held
      if (r.aw_got && r.w_got && !r.bvalid)
      begin
         next_r.aw_got = 1'b0;
         next_r.w_got = 1'b0;
         next_r.bvalid = 1'b1;
         next_r.bresp = RESP_OKAY;
         case (r.aw_addr)
            OFS_CLK_CFG:
            begin
               wv = merge(r.clk_cfg, r.w_data, r.w_strb) & CLK_CFG_WMASK;
               if (wv[CFG_FREQ_LSB +: 3] > FREQ_CODE_MAX)
               begin
                  wv[CFG_FREQ_LSB +: 3] = r.clk_cfg[CFG_FREQ_LSB +: 3];
               end
               next_r.clk_cfg = wv;
            end
            OFS_PLL_DIV:
            begin
               wv = merge(r.pll_div, r.w_data, r.w_strb) & PLL_DIV_WMASK;
               if (wv[DIV_FB_LSB +: 8] < FB_DIV_MIN)
               begin
                  wv[DIV_FB_LSB +: 8] = FB_DIV_MIN;
               end
               next_r.pll_div = wv;
            end
            OFS_STATUS:
            begin
               next_r.bresp = RESP_OKAY;
            end
            OFS_MODE:
            begin
               wv = merge(32'h0000_0000, r.w_data, r.w_strb);
               mode_wr = 1'b1;
               mode_val = wv[1:0];
            end
            OFS_TEMPLATE:
            begin
               wv = merge(r.template, r.w_data, r.w_strb);
               next_r.template = wv & TEMPLATE_WMASK;
               next_r.cpu_run = wv[0];
            end
            OFS_ALT_TEMPLATE:
            begin
               wv = merge(r.alt_template, r.w_data, r.w_strb);
               next_r.alt_template = wv & TEMPLATE_WMASK;
            end
            OFS_SLOW_TICK:
            begin
               slow_clr = 1'b1;
            end
            OFS_FAST_TICK:
            begin
               wv = merge(r.fast_cfg, r.w_data, r.w_strb);
               next_r.fast_cfg = wv & FAST_WMASK;
            end
            OFS_TICK_CFG:
            begin
               wv = merge(r.tick_cfg, r.w_data, r.w_strb);
               next_r.tick_cfg = wv & TICK_WMASK;
            end
            default:
            begin
               next_r.bresp = RESP_SLVERR;
            end
         endcase
      end

      // read answer one cycle after address
      if (r.rvalid && s_axi_rready)
      begin
         next_r.rvalid = 1'b0;
      end
      if (s_axi_arvalid && !r.rvalid)
      begin
         next_r.rvalid = 1'b1;
         next_r.rresp = RESP_OKAY;
         next_r.rdata = 32'h0000_0000;
         case ({s_axi_araddr[7:2], 2'b00})
            OFS_CLK_CFG: next_r.rdata = r.clk_cfg;
            OFS_PLL_DIV: next_r.rdata = r.pll_div;
            OFS_STATUS:
            begin
               next_r.rdata[ST_LOCK] = r.lock;
               next_r.rdata[ST_MODE_LSB +: 2] =
                  mode_code(r.state, r.from_hib);
               next_r.rdata[ST_CPU] = r.cpu_run;
            end
            OFS_MODE:
            begin
               next_r.rdata[1:0] = mode_code(r.state, r.from_hib);
            end
            OFS_TEMPLATE: next_r.rdata = r.template;
            OFS_ALT_TEMPLATE: next_r.rdata = r.alt_template;
            OFS_SLOW_TICK: next_r.rdata[12:0] = r.slow_cnt;
            OFS_FAST_TICK:
            begin
               next_r.rdata = r.fast_cfg;
               next_r.rdata[FT_CNT_LSB +: 5] = r.fast_cnt;
            end
            OFS_TICK_CFG: next_r.rdata = r.tick_cfg;
            default: next_r.rresp = RESP_SLVERR;
         endcase
      end

      if (!next_r.clk_cfg[CFG_PLL_EN] || next_r.pll_div != r.pll_div
         || next_r.clk_cfg[CFG_PLL_SRC_LSB +: 2]
         != r.clk_cfg[CFG_PLL_SRC_LSB +: 2])
      begin
         next_r.lock = 1'b0;
         next_r.lock_cnt = 15'h0000;
      end
      else if (!r.lock)
      begin
         if (r.lock_cnt == 15'(PLL_LOCK_CYCLES - 1))
         begin
            next_r.lock = 1'b1;
         end
         else
         begin
            next_r.lock_cnt = r.lock_cnt + 15'h0001;
         end
      end

      next_r.half_cnt = half_tick ? 10'h000 : r.half_cnt + 10'h001;
      if (half_tick)
      begin
         next_r.ls_100k = ~r.ls_100k;
         if (r.div3 == 2'(DIV_33K_HALF - 1))
         begin
            next_r.div3 = 2'h0;
            next_r.ls_33k = ~r.ls_33k;
         end
         else
         begin
            next_r.div3 = r.div3 + 2'h1;
         end
         if (r.div1k == 7'(DIV_1K_HALF - 1))
         begin
            next_r.div1k = 7'h00;
            next_r.ls_1k = ~r.ls_1k;
         end
         else
         begin
            next_r.div1k = r.div1k + 7'h01;
         end
      end

      if (slow_clr)
      begin
         next_r.slow_cnt = 13'h0000;
      end
      else if (rise_1k && r.state != st_hib && !debug_halt)
      begin
         next_r.slow_cnt = r.slow_cnt + 13'h0001;
         next_r.slow_irq = r.tick_cfg[TC_EN]
            & period_hit(next_r.slow_cnt, r.tick_cfg[TC_SEL_LSB +: 4]);
      end

      if (rise_100k && r.state != st_hib)
      begin
         if (r.fast_cnt >= r.fast_cfg[FT_TERM_LSB +: 5])
         begin
            next_r.fast_cnt = 5'h00;
            next_r.fast_irq = r.fast_cfg[FT_IRQ_EN];
         end
         else
         begin
            next_r.fast_cnt = r.fast_cnt + 5'h01;
         end
      end

      if (watch_rise)
      begin
         next_r.watch_cnt = r.watch_cnt + 15'h0001;
         next_r.second_irq = r.watch_cnt == 15'h7fff;
      end

      // power mode sequencing
      case (r.state)
         st_active, st_alt:
         begin
            if (wake_any)
            begin
               next_r.state = st_active;
               next_r.cpu_run = 1'b1;
            end
            else if (mode_wr)
            begin
               case (mode_val)
                  MODE_ALT: next_r.state = st_alt;
                  MODE_SLEEP: next_r.state = st_sleep;
                  MODE_HIB: next_r.state = st_hib;
                  default: next_r.state = st_active;
               endcase
            end
         end
         st_sleep:
         begin
            if (wake_any)
            begin
               next_r.state = st_resume;
               next_r.from_hib = 1'b0;
               next_r.resume_cnt = 14'h0000;
            end
         end
         st_hib:
         begin
            if (r.s_io[1])
            begin
               next_r.state = st_resume;
               next_r.from_hib = 1'b1;
               next_r.resume_cnt = 14'h0000;
            end
         end
         st_resume:
         begin
            if ((!r.from_hib
               && r.resume_cnt == 14'(SLEEP_RESUME_CYC - 1))
               || (r.from_hib
               && r.resume_cnt == 14'(HIB_RESUME_CYCLES - 1)))
            begin
               next_r.state = st_active;
               next_r.cpu_run = 1'b1;
            end
            else
            begin
               next_r.resume_cnt = r.resume_cnt + 14'h0001;
            end
         end
         default: next_r.state = st_active;
      endcase

      // template gating, bit 0 from run flag
      case (next_r.state)
         st_active:
            next_r.clk_en = {next_r.template[15:1], next_r.cpu_run};
         st_alt:
            next_r.clk_en = next_r.alt_template[15:0]
               & {15'h7fff, next_r.cpu_run};
         default: next_r.clk_en = 16'h0000;
      endcase
   end

   // configuration survives every mode
   always_ff @(posedge clock or negedge rst_n)
   begin
      if (!rst_n)
      begin
         r <= '0;
         r.s_external_reset_pin <= 2'h3;
         r.clk_cfg <= CLK_CFG_RST;
         r.pll_div <= PLL_DIV_RST;
         r.template <= TEMPLATE_RST;
         r.alt_template <= ALT_TEMPLATE_RST;
         r.fast_cfg <= FAST_RST;
         r.tick_cfg <= TICK_RST;
         r.cpu_run <= 1'b1;
         r.clk_en <= TEMPLATE_RST[15:0];
      end
      else if (ce)
      begin
         r <= next_r;
      end
   end

   // registered outputs
   assign s_axi_bvalid = r.bvalid;
   assign s_axi_bresp = r.bresp;
   assign s_axi_rvalid = r.rvalid;
   assign s_axi_rdata = r.rdata;
   assign s_axi_rresp = r.rresp;
   assign main_osc_freq_sel = r.clk_cfg[CFG_FREQ_LSB +: 3];
   assign doubler_enable = r.clk_cfg[CFG_DBL_EN];
   assign doubler_src = r.clk_cfg[CFG_DBL_SRC_LSB +: 2];
   assign pll_enable = r.clk_cfg[CFG_PLL_EN];
   assign pll_ref_src = r.clk_cfg[CFG_PLL_SRC_LSB +: 2];
   assign pll_in_div = r.pll_div[DIV_IN_LSB +: 4];
   assign pll_fb_div = r.pll_div[DIV_FB_LSB +: 8];
   assign pll_lock = r.lock;
   assign pll_output_select = r.lock;
   assign low_speed_100k_clock = r.ls_100k;
   assign low_speed_33k_clock = r.ls_33k;
   assign low_speed_1k_clock = r.ls_1k;
   assign slow_tick_irq = r.slow_irq;
   assign fast_tick_irq = r.fast_irq;
   assign second_tick_irq = r.second_irq;
   assign resource_clk_en = r.clk_en;
   assign cpu_enable = r.clk_en[0];
   assign power_mode = mode_code(r.state, r.from_hib);
endmodule

// >>> cpmc_crystal_model.sv
// Purpose: watch crystal model
// Assumes: free-running 32.768 kHz
// Notes: half period in whole ns
`timescale 1ns/1ns
module cpmc_crystal_model
#(
   parameter int HALF_NS = 15259
)
(
   output logic watch_crystal_osc
);
   // crystal feeds tick
   // runs free, a real crystal never pauses
   initial
   begin
      watch_crystal_osc = 1'b0;
      forever
         #HALF_NS watch_crystal_osc = ~watch_crystal_osc;
   end
endmodule

// >>> cpmc_assertions.sv
// Purpose: port checker for the block
// Assumes: one clock, raw reset pin disables
// Notes: long spans kept in helper counters
`timescale 1ns/1ns
module cpmc_assertions
import cpmc_pkg::*;
#(
   parameter int unsigned HIB_RESUME_CYCLES = 30
)
(
   input wire logic clock,
   input wire logic nrst,
   input wire logic s_axi_bvalid,
   input wire logic wake_irq,
   input wire logic io_wake_pin,
   input wire logic pll_enable,
   input wire logic pll_lock,
   input wire logic [2:0] main_osc_freq_sel,
   input wire logic low_speed_100k_clock,
   input wire logic low_speed_33k_clock,
   input wire logic [15:0] resource_clk_en,
   input wire logic [1:0] power_mode
);
   logic [10:0] hi100;
   logic [10:0] hi33;
   logic [15:0] wk;
   logic low;
   assign low = power_mode == MODE_SLEEP || power_mode == MODE_HIB;
   // high-phase lengths, cycles since wake
   always_ff @(posedge clock or negedge nrst)
      if (!nrst)
      begin
         hi100 <= '0;
         hi33 <= '0;
         wk <= '0;
      end
      else
      begin
         hi100 <= low_speed_100k_clock ? hi100 + 1'b1 : '0;
         hi33 <= low_speed_33k_clock ? hi33 + 1'b1 : '0;
         wk <= (low && (wk != 0 || io_wake_pin ||
            (power_mode == MODE_SLEEP && wake_irq))) ? wk + 1'b1 : '0;
      end
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!nrst);
   sequence s_left_sleep;
      $past(power_mode) == MODE_SLEEP && power_mode == MODE_ACTIVE;
   endsequence
   sequence s_left_hib;
      $past(power_mode) == MODE_HIB && power_mode == MODE_ACTIVE;
   endsequence
   property p_lock_wait;
      $rose(pll_enable) |-> !pll_lock [*8];
   endproperty
   a_lock_wait: assert property (p_lock_wait) else $error("early lock");
   property p_freq;
      main_osc_freq_sel <= FREQ_CODE_MAX;
   endproperty
   a_freq: assert property (p_freq) else $error("bad freq code");
   property p_duty100;
      $fell(low_speed_100k_clock) |-> hi100 == 11'd625;
   endproperty
   a_duty100: assert property (p_duty100) else $error("100k duty");
   property p_div33;
      $fell(low_speed_33k_clock) |-> hi33 == 11'd1875;
   endproperty
   a_div33: assert property (p_div33) else $error("33k divide");
   property p_gate;
      low |-> resource_clk_en == 16'h0000;
   endproperty
   a_gate: assert property (p_gate) else $error("clocks not gated");
   property p_sleep_exit;
      s_left_sleep |-> wk >= 1874 && wk <= 1880;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("resume");
   property p_hib_exit;
      s_left_hib |-> wk + 1 >= HIB_RESUME_CYCLES &&
         wk <= HIB_RESUME_CYCLES + 6;
   endproperty
   a_hib_exit: assert property (p_hib_exit) else $error("hib wake");
   property p_lp_req;
      $past(power_mode) == MODE_ACTIVE && power_mode != MODE_ACTIVE
         |-> $past(s_axi_bvalid) || s_axi_bvalid;
   endproperty
   a_lp_req: assert property (p_lp_req) else $error("mode unasked");
endmodule
bind cpmc_top cpmc_assertions #(.HIB_RESUME_CYCLES(HIB_RESUME_CYCLES)) u_chk
(
   .clock, .nrst, .s_axi_bvalid, .wake_irq, .io_wake_pin, .pll_enable,
   .pll_lock, .main_osc_freq_sel, .low_speed_100k_clock,
   .low_speed_33k_clock, .resource_clk_en, .power_mode
);

// >>> test_clock_power_mode_control.sv
// Purpose: self-checking bench
// Assumes: shortened lock and hibernate resume counts
// Notes: registers reached over AXI4-Lite tasks
`timescale 1ns/1ns
module test_clock_power_mode_control;
   import cpmc_pkg::*;
   typedef struct {logic [7:0] a; logic [31:0] w, e, m; logic [1:0] s;}
      cpmc_row_type;
   logic clock = 0, nrst = 0, ce = 1, s_axi_awvalid = 0, s_axi_wvalid = 0;
   logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata, d;
   logic [3:0] s_axi_wstrb = 4'hf, pll_in_div;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic [1:0] s_axi_bresp, s_axi_rresp, doubler_src, pll_ref_src, r;
   logic external_reset_pin_n = 1, io_wake_pin = 0, wake_irq = 0;
   logic watchdog_reset = 0, precision_reset = 0, debug_halt = 0;
   logic [2:0] main_osc_freq_sel;
   logic [7:0] pll_fb_div;
   logic [15:0] resource_clk_en;
   logic [1:0] power_mode;
   logic doubler_enable, pll_enable, pll_lock, pll_output_select;
   logic low_speed_100k_clock, low_speed_33k_clock, low_speed_1k_clock;
   logic slow_tick_irq, fast_tick_irq, second_tick_irq, cpu_enable;
   logic watch_crystal_osc, s_axi_rvalid;
   int num_errors = 0, checked = 0, n, i;
   // offset, write, expect, mask, resp
   cpmc_row_type rows [5] = '{
      '{8'h00, 32'h7, 32'h0, 32'h1ff, RESP_OKAY},
      '{8'h04, 32'h201, 32'h401, 32'hff0f, RESP_OKAY},
      '{8'h14, 32'hffff1234, 32'h1234, 32'hffffffff, RESP_OKAY},
      '{8'h08, 32'hf, 32'h8, 32'hffffffff, RESP_OKAY},
      '{8'h24, 32'h1, 32'h0, 32'h0, RESP_SLVERR}};
   cpmc_top #(.PLL_LOCK_CYCLES(20), .HIB_RESUME_CYCLES(30)) dut
   (
      .clock, .nrst, .ce, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
      .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
      .s_axi_arready, .s_axi_araddr, .s_axi_rvalid, .s_axi_rready,
      .s_axi_rdata, .s_axi_rresp, .external_reset_pin_n, .io_wake_pin,
      .watch_crystal_osc, .watchdog_reset, .precision_reset, .wake_irq,
      .debug_halt, .main_osc_freq_sel, .doubler_enable, .doubler_src,
      .pll_enable, .pll_ref_src, .pll_in_div, .pll_fb_div, .pll_lock,
      .pll_output_select, .low_speed_100k_clock, .low_speed_33k_clock,
      .low_speed_1k_clock, .slow_tick_irq, .fast_tick_irq,
      .second_tick_irq, .resource_clk_en, .cpu_enable, .power_mode
   );
   cpmc_crystal_model xtal (.watch_crystal_osc);
   always #4 clock = ~clock;
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic final_report;
      $display("checked=%0d num_errors=%0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task automatic tmo;
      num_errors++;
      final_report;
   endtask
   // aw and w together, each dropped once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] w);
      @(posedge clock);
      s_axi_awaddr <= a;
      s_axi_wdata <= w;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      for (n = 0; n < 50 && s_axi_bvalid !== 1; n++)
      begin
         @(posedge clock);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end
      if (n == 50) tmo;
      s_axi_bready <= 0;
      r = s_axi_bresp;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clock);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      for (n = 0; n < 50 && s_axi_rvalid !== 1; n++)
      begin
         @(posedge clock);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end
      if (n == 50) tmo;
      s_axi_rready <= 0;
      r = s_axi_rresp;
      d = s_axi_rdata;
   endtask
   task automatic wait_mode(input int lim);
      for (n = 0; n < lim && power_mode !== MODE_ACTIVE; n++)
         @(posedge clock);
      if (n == lim) tmo;
   endtask
   initial
   begin
      repeat (16) @(posedge clock);
      nrst <= 1;
      repeat (3) @(posedge clock);
      chk(power_mode, MODE_ACTIVE);
      chk(resource_clk_en, 16'hffff);
      for (i = 0; i < 5; i++)
      begin
         wr(rows[i].a, rows[i].w);
         chk(r, rows[i].s);
         rd(rows[i].a);
         chk(r, rows[i].s);
         chk(d & rows[i].m, rows[i].e);
      end
      for (i = 0; i < 6; i++)
      begin
         wr(OFS_CLK_CFG, i);
         chk(main_osc_freq_sel, i);
      end
      $display("regs done");
      wr(OFS_CLK_CFG, 32'h80);
      for (n = 0; n < 100 && pll_lock !== 1; n++)
         @(posedge clock);
      if (n == 100) tmo;
      chk(n > 10, 1);
      chk(pll_output_select, 1);
      wr(OFS_CLK_CFG, 32'h0);
      chk(pll_lock, 0);
      $display("lock done");
      wr(OFS_TEMPLATE, 32'hfffe);
      chk(cpu_enable, 0);
      wr(OFS_MODE, MODE_SLEEP);
      repeat (500) @(posedge clock);
      chk(power_mode, MODE_SLEEP);
      wake_irq <= 1;
      @(posedge clock);
      wake_irq <= 0;
      wait_mode(3000);
      chk(n > 1800, 1);
      chk(cpu_enable, 1);
      $display("sleep done");
      wr(OFS_MODE, MODE_HIB);
      wake_irq <= 1;
      @(posedge clock);
      wake_irq <= 0;
      repeat (50) @(posedge clock);
      chk(power_mode, MODE_HIB);
      io_wake_pin <= 1;
      repeat (2) @(posedge clock);
      io_wake_pin <= 0;
      wait_mode(200);
      $display("hib done");
      wr(OFS_FAST_TICK, 32'h103);
      for (n = 0; n < 6000 && fast_tick_irq !== 1; n++)
         @(posedge clock);
      if (n == 6000) tmo;
      @(posedge clock);
      for (n = 1; n < 6000 && fast_tick_irq !== 1; n++)
         @(posedge clock);
      chk(n, 5000);
      $display("fast done");
      final_report;
   end
endmodule
